// *** core/fosl_loader.sv ***
/*
 * Flag offset serial loader: holds the eight almost-empty / almost-full
 * offsets of a four-queue device in one shift chain, loaded with defaults
 * at master reset and written or read back over the serial port or the
 * test port data register.
 * Assumes all pins but reset and the register bus are asynchronous to clock and change slowly compared
 * with it (serial clock period 800 ns); a test access port controller
 * outside supplies instruction, shift strobe, clock and data.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Default offset 7/63/127/1023 from select input
// - Same default for all eight offsets
// - All offsets form one shift chain
// - Write enable low shifts serial in
// - Read enable low shifts chain out
// - Zeros follow once chain is read out
// - Instruction 0x0008 writes chain from TDI
// - Instruction 0x0007 reads chain to TDO
// - Chain length follows depth and width
// - Each field least significant bit first
// - Chain covers all four offset pairs
// - Same programming in either timing mode
// - No parallel load path exists
// - Select inputs sampled during master reset
// - Queue3 empty first, queue0 full last
// - Serial in picks timing mode at reset
module fosl_loader #(
   parameter logic [1:0] DEPTH_VARIANT = 2'h0     // 0 smallest .. 2 largest
) (
   input  wire logic                      clock,
   input  wire logic                      reset,
   input  wire logic                      master_reset_n,
   input  wire logic [1:0]                default_offset_select,
   input  wire logic [1:0]                port_width_select,
   input  wire logic                      serial_clock,
   input  wire logic                      serial_write_enable_n,
   input  wire logic                      serial_read_enable_n,
   input  wire logic                      mode_select_serial_in,
   output logic                           serial_prog_out,
   input  wire logic                      jtag_tck,
   input  wire logic                      jtag_tdi,
   input  wire logic                      jtag_shift_dr,
   input  wire logic [15:0]               jtag_instruction,
   output logic                           jtag_tdo,
   output logic                           first_word_fallthrough_mode,
   output fosl_pkg::fosl_offset_t [3:0]   almost_empty_offset,
   output fosl_pkg::fosl_offset_t [3:0]   almost_full_offset,
   input  wire fosl_pkg::fosl_avm_req_t   avs_req,
   output logic [31:0]                    avs_readdata,
   output logic                           avs_waitrequest
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [fosl_pkg::FOSL_S_BITS-1:0]        s1;       // Sync stage one
      logic [fosl_pkg::FOSL_S_BITS-1:0]        s2;       // Sync stage two
      logic [fosl_pkg::FOSL_S_BITS-1:0]        s3;       // Sync stage three
      logic [fosl_pkg::FOSL_S_BITS-1:0]        stable;   // Agreed pin levels
      logic [fosl_pkg::FOSL_CHAIN_MAX-1:0]     chain;    // Offset chain
      logic [fosl_pkg::FOSL_CHAIN_MAX-1:0]     scan;     // Readout copy
      logic [fosl_pkg::FOSL_FIELDS-1:0][16:0]  offs;     // Registered fields
      logic [1:0]                              dsel;     // Captured select
      logic [1:0]                              pw;       // Captured width
      logic                                    tmode;    // Captured mode
      logic                                    sout;     // Serial data out
      logic                                    tdo;      // Test data out
      logic                                    ser_en;   // Serial port enable
      logic                                    ack;      // Bus answer cycle
      logic [31:0]                             rdata;    // Bus read data
   } fosl_state_t;

   fosl_state_t q;                 // Registered state
   fosl_state_t d;                 // Next state

   // ----------------------------------------------------------------------
   // Pin events
   // ----------------------------------------------------------------------
   logic [fosl_pkg::FOSL_S_BITS-1:0] stable_nx;   // Levels after this edge
   logic [fosl_pkg::FOSL_S_BITS-1:0] rise;        // Agreed rising edges
   logic [fosl_pkg::FOSL_S_BITS-1:0] fall;        // Agreed falling edges
   logic       mrst_act;      // Master reset held low
   logic       wr_evt;        // Serial write shift
   logic       rd_evt;        // Serial read shift
   logic       rd_start;      // Serial readout begins
   logic       jwr_evt;       // Test port write shift
   logic       jrd_evt;       // Test port read shift
   logic       jrd_start;     // Test port readout begins
   logic       instr_wr;      // Write instruction loaded
   logic       instr_rd;      // Read instruction loaded
   logic [4:0] fw;            // Field width in bits
   logic [7:0] clen;          // Chain length in bits
   logic [16:0] dflt;         // Default offset value
   logic        bit_in;       // Bit entering the chain
   logic        bus_req;      // Bus request pending
   logic [2:0]  widx;         // Offset word index

   // A rise counts once stages two and three agree, a fall as soon as they differ
   always_comb begin
      stable_nx = (q.stable & ~(q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
      rise      = stable_nx & ~q.stable;
      fall      = ~stable_nx & q.stable;
   end

   // Event decode from agreed levels
   always_comb begin
      mrst_act  = ~stable_nx[fosl_pkg::FOSL_S_MRST];
      instr_wr  = stable_nx[fosl_pkg::FOSL_S_INSTR +: 16] == fosl_pkg::FOSL_INSTR_WRITE;
      instr_rd  = stable_nx[fosl_pkg::FOSL_S_INSTR +: 16] == fosl_pkg::FOSL_INSTR_READ;
      // Write wins if the host lowers both enables
      wr_evt    = q.ser_en && !mrst_act && rise[fosl_pkg::FOSL_S_SCLK]
                  && !stable_nx[fosl_pkg::FOSL_S_WREN];
      rd_evt    = q.ser_en && !mrst_act && rise[fosl_pkg::FOSL_S_SCLK]
                  && !stable_nx[fosl_pkg::FOSL_S_RDEN]
                  && stable_nx[fosl_pkg::FOSL_S_WREN];
      rd_start  = q.ser_en && fall[fosl_pkg::FOSL_S_RDEN];
      jwr_evt   = !mrst_act && instr_wr && rise[fosl_pkg::FOSL_S_TCK]
                  && stable_nx[fosl_pkg::FOSL_S_SHIFT];
      jrd_evt   = !mrst_act && instr_rd && rise[fosl_pkg::FOSL_S_TCK]
                  && stable_nx[fosl_pkg::FOSL_S_SHIFT];
      jrd_start = instr_rd && rise[fosl_pkg::FOSL_S_SHIFT];
   end

   // ----------------------------------------------------------------------
   // Geometry and default
   // ----------------------------------------------------------------------
   // Field width grows one bit per depth step and per narrower port
   always_comb begin
      case (q.pw)
         fosl_pkg::FOSL_PW_X10: fw = fosl_pkg::FOSL_FIELD_BASE + {3'h0, DEPTH_VARIANT}
                                     + {3'h0, fosl_pkg::FOSL_STEP_X10};
         fosl_pkg::FOSL_PW_X20: fw = fosl_pkg::FOSL_FIELD_BASE + {3'h0, DEPTH_VARIANT}
                                     + {3'h0, fosl_pkg::FOSL_STEP_X20};
         default:               fw = fosl_pkg::FOSL_FIELD_BASE + {3'h0, DEPTH_VARIANT}
                                     + {3'h0, fosl_pkg::FOSL_STEP_X40};
      endcase
      clen = {fw, 3'h0};
   end

   // Default value from the select captured at master reset
   always_comb begin
      case (stable_nx[fosl_pkg::FOSL_S_DSEL +: 2])
         2'h0:    dflt = fosl_pkg::FOSL_DFLT_0;
         2'h1:    dflt = fosl_pkg::FOSL_DFLT_1;
         2'h2:    dflt = fosl_pkg::FOSL_DFLT_2;
         default: dflt = fosl_pkg::FOSL_DFLT_3;
      endcase
   end

   // Source bit for a shift, serial pin or test data in
   always_comb begin
      bit_in = jwr_evt ? stable_nx[fosl_pkg::FOSL_S_TDI] : stable_nx[fosl_pkg::FOSL_S_SI];
   end

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   always_comb begin
      bus_req         = avs_req.read || avs_req.write;
      avs_waitrequest = bus_req && !q.ack;
      widx            = 3'(({2'h0, avs_req.address} - {2'h0, fosl_pkg::FOSL_ADDR_OFFS}) >> 2);
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;
      // Three-stage pin synchronisers
      d.s1 = {jtag_instruction, port_width_select, default_offset_select,
              jtag_shift_dr, jtag_tdi, jtag_tck, mode_select_serial_in,
              serial_read_enable_n, serial_write_enable_n, serial_clock,
              master_reset_n};
      d.s2     = q.s1;
      d.s3     = q.s2;
      d.stable = stable_nx;

      // Chain holds unless a shift or master reset is seen
      if (mrst_act) begin
         // Configuration sampled throughout master reset
         d.dsel  = stable_nx[fosl_pkg::FOSL_S_DSEL +: 2];
         d.pw    = stable_nx[fosl_pkg::FOSL_S_PW +: 2];
         d.tmode = stable_nx[fosl_pkg::FOSL_S_SI];
         // Same default in every field of every queue
         for (int i = 0; i < fosl_pkg::FOSL_CHAIN_MAX; i++) begin
            if (i < int'(clen)) begin
               d.chain[i] = dflt[i % int'(fw)];
            end else begin
               d.chain[i] = 1'b0;
            end
         end
         d.scan = '0;
      end else if (wr_evt || jwr_evt) begin
         // Only path into the offsets outside master reset is this shift
         for (int i = 0; i < fosl_pkg::FOSL_CHAIN_MAX; i++) begin
            if (i + 1 < int'(clen)) begin
               d.chain[i] = q.chain[i+1];
            end else if (i + 1 == int'(clen)) begin
               d.chain[i] = bit_in;
            end else begin
               d.chain[i] = 1'b0;
            end
         end
      end

      // Readout copy taken at start, then shifted with zero fill
      if (mrst_act) begin
         d.sout = 1'b0;
         d.tdo  = 1'b0;
      end else if (rd_start || jrd_start) begin
         d.scan = q.chain;
         d.sout = rd_start ? q.chain[0] : q.sout;
         d.tdo  = jrd_start ? q.chain[0] : q.tdo;
      end else if (rd_evt || jrd_evt) begin
         d.scan = q.scan >> 1;
         d.sout = rd_evt ? q.scan[1] : q.sout;
         d.tdo  = jrd_evt ? q.scan[1] : q.tdo;
      end

      // Fields cut from the chain, queue 3 empty at the low end
      for (int k = 0; k < fosl_pkg::FOSL_FIELDS; k++) begin
         for (int b = 0; b < fosl_pkg::FOSL_FIELD_MAX; b++) begin
            if (b < int'(fw)) begin
               d.offs[k][b] = q.chain[k*int'(fw) + b];
            end else begin
               d.offs[k][b] = 1'b0;
            end
         end
      end

      // Bus slave, one wait cycle then answer
      d.ack = bus_req && !q.ack;
      if (bus_req && !q.ack) begin
         if (avs_req.address == fosl_pkg::FOSL_ADDR_CTRL) begin
            d.rdata = {31'h0, q.ser_en};
         end else if (avs_req.address == fosl_pkg::FOSL_ADDR_STATUS) begin
            d.rdata = {19'h0, clen, q.pw, q.dsel, q.tmode};
         end else if (avs_req.address >= fosl_pkg::FOSL_ADDR_OFFS &&
                      avs_req.address <= fosl_pkg::FOSL_ADDR_LAST &&
                      avs_req.address[1:0] == 2'h0) begin
            d.rdata = {15'h0, q.offs[widx]};
         end else begin
            d.rdata = 32'h0;   // Unmapped reads as zero
         end
      end
      // Write lands at the edge where waitrequest is seen low
      if (avs_req.write && q.ack && avs_req.address == fosl_pkg::FOSL_ADDR_CTRL) begin
         d.ser_en = avs_req.writedata[0];
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         q        <= '0;
         q.s1     <= {fosl_pkg::FOSL_S_BITS{1'b1}};
         q.s2     <= {fosl_pkg::FOSL_S_BITS{1'b1}};
         q.s3     <= {fosl_pkg::FOSL_S_BITS{1'b1}};
         q.stable <= {fosl_pkg::FOSL_S_BITS{1'b1}};
         q.ser_en <= fosl_pkg::FOSL_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   always_comb begin
      serial_prog_out             = q.sout;
      jtag_tdo                    = q.tdo;
      first_word_fallthrough_mode = q.tmode;
      avs_readdata                = q.rdata;
      for (int n = 0; n < 4; n++) begin
         almost_empty_offset[n] = q.offs[(3-n)*2];
         almost_full_offset[n]  = q.offs[(3-n)*2+1];
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_default_seven: assert property (
      mrst_act && stable_nx[fosl_pkg::FOSL_S_DSEL +: 2] == 2'h0 ##1 !mrst_act
      |-> ##1 almost_empty_offset[0] == fosl_pkg::FOSL_DFLT_0
          && almost_full_offset[3] == fosl_pkg::FOSL_DFLT_0)
      else $error("default offset not seven");
   chk_write_shift: assert property (
      wr_evt |=> q.chain[clen-1] == $past(stable_nx[fosl_pkg::FOSL_S_SI])
                 && q.chain[0] == $past(q.chain[1]))
      else $error("serial write did not shift");
   chk_read_shift: assert property (
      rd_evt |=> serial_prog_out == $past(q.scan[1]) && q.scan == $past(q.scan) >> 1)
      else $error("serial read did not shift");
   chk_zero_tail: assert property (
      (q.scan == '0) && !rd_start && !jrd_start && !mrst_act ##1 rd_evt
      |=> !serial_prog_out)
      else $error("nonzero after chain read out");
   chk_hold_idle: assert property (
      !wr_evt && !jwr_evt && !mrst_act |=> $stable(q.chain))
      else $error("chain changed while idle");
   chk_jtag_write: assert property (
      jwr_evt |=> q.chain[clen-1] == $past(stable_nx[fosl_pkg::FOSL_S_TDI]))
      else $error("test port write did not shift");
   chk_jtag_read: assert property (
      jrd_evt |=> jtag_tdo == $past(q.scan[1]))
      else $error("test port read wrong bit");
   chk_mode_latch: assert property (
      mrst_act |=> first_word_fallthrough_mode == $past(stable_nx[fosl_pkg::FOSL_S_SI]))
      else $error("timing mode not captured");
   chk_bus_answer: assert property (
      bus_req && avs_waitrequest |=> !avs_waitrequest || !bus_req)
      else $error("bus answer late");
   chk_chain_len: assert property (
      !mrst_act |-> clen == {fw, 3'h0} && fw >= fosl_pkg::FOSL_FIELD_BASE
                    && int'(fw) <= fosl_pkg::FOSL_FIELD_MAX)
      else $error("chain length out of range");
   chk_ctrl_write: assert property (
      avs_req.write && !avs_waitrequest && avs_req.address == fosl_pkg::FOSL_ADDR_CTRL
      |=> q.ser_en == $past(avs_req.writedata[0]))
      else $error("port enable write lost");

   // Main transfers on both ports
   cov_serial_write: cover property (wr_evt ##[1:40] wr_evt);
   cov_serial_read:  cover property (rd_start ##[1:40] rd_evt);
   cov_jtag_write:   cover property (jwr_evt);
   cov_jtag_read:    cover property (jrd_start ##[1:40] jrd_evt);
   cov_read_tail:    cover property ((q.scan == '0) && rd_evt);

endmodule

`default_nettype wire

// *** shared/fosl_pkg.sv ***
/*
 * Constants and types for the flag offset serial loader.
 * Assumes a single 10 MHz clock domain and a synchronous, active-high reset.
 */
package fosl_pkg;

   // ----------------------------------------------------------------------
   // Chain geometry
   // ----------------------------------------------------------------------
   localparam int          FOSL_FIELDS     = 8;        // Four empty/full pairs
   localparam int          FOSL_FIELD_MAX  = 17;       // Widest offset field
   localparam int          FOSL_CHAIN_MAX  = 136;      // Longest chain
   localparam logic [4:0]  FOSL_FIELD_BASE = 5'h0D;    // Smallest field, x40
   localparam logic [1:0]  FOSL_PW_X10     = 2'h0;     // Port width codes
   localparam logic [1:0]  FOSL_PW_X20     = 2'h1;
   localparam logic [1:0]  FOSL_STEP_X10   = 2'h2;     // Extra field bits per width
   localparam logic [1:0]  FOSL_STEP_X20   = 2'h1;
   localparam logic [1:0]  FOSL_STEP_X40   = 2'h0;

   // ----------------------------------------------------------------------
   // Default offsets
   // ----------------------------------------------------------------------
   localparam logic [16:0] FOSL_DFLT_0 = 17'h00007;
   localparam logic [16:0] FOSL_DFLT_1 = 17'h0003F;
   localparam logic [16:0] FOSL_DFLT_2 = 17'h0007F;
   localparam logic [16:0] FOSL_DFLT_3 = 17'h003FF;

   // ----------------------------------------------------------------------
   // Test-port instructions
   // ----------------------------------------------------------------------
   localparam logic [15:0] FOSL_INSTR_WRITE = 16'h0008;
   localparam logic [15:0] FOSL_INSTR_READ  = 16'h0007;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [5:0]  FOSL_ADDR_CTRL   = 6'h00;   // Bit 0 serial port enable
   localparam logic [5:0]  FOSL_ADDR_STATUS = 6'h04;   // Captured configuration
   localparam logic [5:0]  FOSL_ADDR_OFFS   = 6'h08;   // Eight offset words
   localparam logic [5:0]  FOSL_ADDR_LAST   = 6'h24;
   localparam logic        FOSL_CTRL_RESET  = 1'b1;

   // ----------------------------------------------------------------------
   // Synchroniser bit positions
   // ----------------------------------------------------------------------
   localparam int FOSL_S_MRST  = 0;   // Master reset, active low
   localparam int FOSL_S_SCLK  = 1;
   localparam int FOSL_S_WREN  = 2;
   localparam int FOSL_S_RDEN  = 3;
   localparam int FOSL_S_SI    = 4;
   localparam int FOSL_S_TCK   = 5;
   localparam int FOSL_S_TDI   = 6;
   localparam int FOSL_S_SHIFT = 7;
   localparam int FOSL_S_DSEL  = 8;   // Two bits
   localparam int FOSL_S_PW    = 10;  // Two bits
   localparam int FOSL_S_INSTR = 12;  // Sixteen bits
   localparam int FOSL_S_BITS  = 28;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef logic [16:0] fosl_offset_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
   } fosl_avm_req_t;

endpackage

// *** bench/fosl_host_model.sv ***
/*
 * Host model for the serial offset port: clocks chain bits in and out.
 * Assumes the 10 MHz system clock; serial clock idles low between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module fosl_host_model (
   input  wire logic clock,
   input  wire logic serial_prog_out,
   output logic      serial_clock,
   output logic      serial_write_enable_n,
   output logic      serial_read_enable_n,
   output logic      mode_select_serial_in
);
   // -------------------------------------------------------------------
   // Idle port: both enables high, never both low
   // -------------------------------------------------------------------
   initial begin
      serial_clock          = 1'b0;
      serial_write_enable_n = 1'b1;
      serial_read_enable_n  = 1'b1;
      mode_select_serial_in = 1'b0;
   end
   // One serial clock period; bit sampled just before the rise
   task automatic pulse(output logic b);
      repeat (4) @(posedge clock);
      b = serial_prog_out;
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clock <= 1'b0;
   endtask
   // Serial in level seen during master reset
   task automatic set_mode(input logic mode);
      mode_select_serial_in <= mode;
   endtask
   // First n chain bits in, lowest first; enable level chosen by caller
   task automatic shift_in(input logic [135:0] bits, input int n, input logic wen_n);
      logic b;
      @(posedge clock);
      serial_write_enable_n <= wen_n;
      for (int i = 0; i < n; i++) begin
         mode_select_serial_in <= bits[i];
         pulse(b);
      end
      repeat (4) @(posedge clock);
      serial_write_enable_n <= 1'b1;
      mode_select_serial_in <= ~mode_select_serial_in;
   endtask
   // Readout with read enable low throughout
   task automatic read_out(output logic [135:0] bits, input int n);
      bits = '0;
      @(posedge clock);
      serial_read_enable_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (int i = 0; i < n; i++) pulse(bits[i]);
      repeat (4) @(posedge clock);
      serial_read_enable_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** bench/flag_offset_serial_loader_tb.sv ***
/*
 * Testbench for the flag offset serial loader: defaults, serial load,
 * readback and register bus. Assumes x40 width and smallest depth (104 bits).
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module flag_offset_serial_loader_tb;
   logic                         clock = 1'b0;
   logic                         reset = 1'b1;
   logic                         master_reset_n = 1'b1;
   logic [1:0]                   dsel = 2'h0;
   fosl_pkg::fosl_avm_req_t      avs_req = '0;
   logic [31:0]                  avs_readdata;
   logic                         avs_waitrequest;
   logic                         sclk, wren_n, rden_n, si, prog_out, tmode;
   logic [1:0]                   pw = 2'h2;
   logic                         tck = 1'b0;
   logic                         tdi = 1'b0;
   logic                         shift_dr = 1'b0;
   logic [15:0]                  instr = 16'h0000;
   logic                         tdo;
   logic [7:0]                   clen_exp [4] = '{8'h78, 8'h70, 8'h68, 8'h68};
   logic [1:0]                   pw_sel [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   fosl_pkg::fosl_offset_t [3:0] ae, af;
   logic [135:0]                 chain, rb;
   logic [31:0]                  rd;
   logic [16:0]                  dflt [4] = '{17'h00007, 17'h0003F, 17'h0007F, 17'h003FF};
   int                           num_errors = 0;
   int                           tests_run = 0;
   // -------------------------------------------------------------------
   // Clock, design and host
   // -------------------------------------------------------------------
   always #50 clock = ~clock;
   fosl_loader DUT (.clock(clock), .reset(reset), .master_reset_n(master_reset_n),
      .default_offset_select(dsel), .port_width_select(pw), .serial_clock(sclk),
      .serial_write_enable_n(wren_n), .serial_read_enable_n(rden_n),
      .mode_select_serial_in(si), .serial_prog_out(prog_out), .jtag_tck(tck), .jtag_tdi(tdi),
      .jtag_shift_dr(shift_dr), .jtag_instruction(instr), .jtag_tdo(tdo),
      .first_word_fallthrough_mode(tmode), .almost_empty_offset(ae), .almost_full_offset(af),
      .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   fosl_host_model HOST (.clock(clock), .serial_prog_out(prog_out), .serial_clock(sclk),
      .serial_write_enable_n(wren_n), .serial_read_enable_n(rden_n),
      .mode_select_serial_in(si));
   // One Avalon transfer, held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      @(posedge clock);
      avs_req <= fosl_pkg::fosl_avm_req_t'{read: !wr, write: wr, address: a, writedata: wd};
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_req <= '0;
   endtask
   // Master reset with a default select and timing mode
   task automatic mreset(input logic [1:0] s, input logic m, input logic [1:0] w);
      @(posedge clock);
      master_reset_n <= 1'b0;
      dsel <= s;
      pw <= w;
      HOST.set_mode(m);
      repeat (10) @(posedge clock);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
   // Offsets on the outputs and in the offset words against a chain image
   task automatic check_offs();
      for (int k = 0; k < 8; k++) begin
         bus(1'b0, 6'(8 + 4 * k), 32'h0);
         `CHK(rd, {19'h0, chain[13*k +: 13]})
      end
      for (int q = 0; q < 4; q++) begin
         `CHK(ae[q], {4'h0, chain[26*(3-q) +: 13]})
         `CHK(af[q], {4'h0, chain[26*(3-q)+13 +: 13]})
      end
   endtask
   // Test port data shift under an instruction, lowest bit first
   task automatic jtag(input logic [15:0] ins, input logic [135:0] bits, input int n,
                       output logic [135:0] got);
      got = '0;
      @(posedge clock);
      instr <= ins;
      repeat (4) @(posedge clock);
      shift_dr <= 1'b1;
      repeat (4) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         tdi <= bits[i];
         repeat (4) @(posedge clock);
         got[i] = tdo;
         tck <= 1'b1;
         repeat (4) @(posedge clock);
         tck <= 1'b0;
      end
      repeat (4) @(posedge clock);
      shift_dr <= 1'b0;
      instr <= 16'h0000;
   endtask
   // Verdict and end of run
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // -------------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      bus(1'b0, 6'h00, 32'h0);
      `CHK(rd, 32'h1)
      bus(1'b1, 6'h00, 32'h0);
      bus(1'b0, 6'h00, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b1, 6'h00, 32'h1);
      bus(1'b0, 6'h28, 32'h0);
      `CHK(rd, 32'h0)
      for (int s = 0; s < 4; s++) begin
         mreset(2'(s), s[0], pw_sel[s]);
         for (int q = 0; q < 4; q++) begin
            `CHK(ae[q], dflt[s])
            `CHK(af[q], dflt[s])
         end
         `CHK(tmode, s[0])
         bus(1'b0, 6'h04, 32'h0);
         `CHK(rd, {19'h0, clen_exp[s], pw_sel[s], 2'(s), s[0]})
      end
      chain = '0;
      for (int k = 0; k < 8; k++) chain[13*k +: 13] = 13'(13'h0A00 + k * 13'h0111);
      HOST.shift_in(chain, 104, 1'b0);
      repeat (4) @(posedge clock);
      check_offs();
      bus(1'b1, 6'h00, 32'h0);
      HOST.shift_in(~chain, 8, 1'b0);
      check_offs();
      bus(1'b1, 6'h00, 32'h1);
      HOST.shift_in(~chain, 8, 1'b1);
      check_offs();
      HOST.read_out(rb, 108);
      `CHK(rb[103:0], chain[103:0])
      `CHK(rb[107:104], 4'h0)
      mreset(2'h1, 1'b0, 2'h2);
      chain[103:0] = ~chain[103:0];
      jtag(fosl_pkg::FOSL_INSTR_WRITE, chain, 104, rb);
      check_offs();
      jtag(fosl_pkg::FOSL_INSTR_READ, '0, 108, rb);
      `CHK(rb[103:0], chain[103:0])
      `CHK(rb[107:104], 4'h0)
      final_report();
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
